//--- hdl/pfc_ctrl.sv
// program flash control register and its read and write sequencing
`timescale 1ns/1ps
`default_nettype none
`include "pfc_map.svh"

module pfc_ctrl
    import pfc_pkg::*;
(
    // clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_srst,
    // special function register port
    input  wire logic        i_sfr_wr,
    input  wire logic [7:0]  i_sfr_wdata,
    output logic      [7:0]  o_sfr_rdata,
    // flash controller
    input  wire logic [12:0] i_flash_addr,
    input  wire logic [13:0] i_flash_rdata,
    input  wire logic        i_wr_done,
    output logic             o_flash_rd,
    output logic             o_flash_cal,
    output logic             o_wr_start,
    // core side
    output logic             o_skip_instr,
    output logic             o_read_valid,
    output logic      [13:0] o_read_word
);

    // ****************************************
    // control register
    // ****************************************
    pfc_ctrl_s     ctrl_reg;
    logic          cal_select_reg;
    logic          write_allow_reg;
    logic          write_trig_reg;
    logic          read_trig_reg;
    pfc_rd_state_e rd_state_reg;
    pfc_wr_state_e wr_state_reg;
    logic          hidden_addr;
    logic          wr_ok;
    logic          rd_launch;

    // one flop per bit keeps a single driver each; the struct is only a view
    assign ctrl_reg    = {cal_select_reg, write_allow_reg, write_trig_reg, read_trig_reg};
    assign hidden_addr = o_flash_cal && ((i_flash_addr == `PFC_CAL_CONFIG_ADDR) ||
                                         (i_flash_addr == `PFC_CAL_ID_ADDR));
    assign wr_ok       = ctrl_reg.write_allow && !ctrl_reg.cal_select;
    assign rd_launch   = i_sfr_wr && i_sfr_wdata[`PFC_BIT_RD] && !ctrl_reg.read_trig;

    always_comb begin
        o_sfr_rdata                = `PFC_CTRL_RESET;
        o_sfr_rdata[`PFC_BIT_CAL]   = ctrl_reg.cal_select;
        o_sfr_rdata[`PFC_BIT_ALLOW] = ctrl_reg.write_allow;
        o_sfr_rdata[`PFC_BIT_WR]    = ctrl_reg.write_trig;
        o_sfr_rdata[`PFC_BIT_RD]    = ctrl_reg.read_trig;
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            cal_select_reg  <= 1'b0;
            write_allow_reg <= 1'b0;
        end else if (i_sfr_wr) begin
            cal_select_reg  <= i_sfr_wdata[`PFC_BIT_CAL];
            write_allow_reg <= i_sfr_wdata[`PFC_BIT_ALLOW];
        end
    end

    // set beats the hardware clear so a request is never lost
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            write_trig_reg <= 1'b0;
        end else if (i_sfr_wr && i_sfr_wdata[`PFC_BIT_WR]) begin
            write_trig_reg <= 1'b1;
        end else if (wr_state_reg == PFC_WR_BUSY && i_wr_done) begin
            write_trig_reg <= 1'b0;
        end else if (wr_state_reg == PFC_WR_IDLE && ctrl_reg.write_trig && !wr_ok) begin
            write_trig_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            read_trig_reg <= 1'b0;
        end else if (rd_launch) begin
            read_trig_reg <= 1'b1;
        end else if (rd_state_reg == PFC_RD_FETCH) begin
            read_trig_reg <= 1'b0;
        end
    end

    // ****************************************
    // write sequencing
    // ****************************************
    // the erase and program timer lives in the flash controller; this only waits for it
    assign o_wr_start = (wr_state_reg == PFC_WR_IDLE) && ctrl_reg.write_trig && wr_ok;

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            wr_state_reg <= PFC_WR_IDLE;
        end else begin
            case (wr_state_reg)
                PFC_WR_IDLE: begin
                    if (o_wr_start) begin
                        wr_state_reg <= PFC_WR_BUSY;
                    end
                end
                PFC_WR_BUSY: begin
                    if (i_wr_done) begin
                        wr_state_reg <= PFC_WR_IDLE;
                    end
                end
                default: begin
                    wr_state_reg <= PFC_WR_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // read sequencing
    // ****************************************
    assign o_flash_cal  = ctrl_reg.cal_select;
    assign o_skip_instr = (rd_state_reg == PFC_RD_FETCH);
    assign o_flash_rd   = (rd_state_reg == PFC_RD_FETCH) && ctrl_reg.read_trig &&
                          !hidden_addr;

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            rd_state_reg <= PFC_RD_IDLE;
        end else begin
            case (rd_state_reg)
                PFC_RD_IDLE: begin
                    if (rd_launch) begin
                        rd_state_reg <= PFC_RD_WAIT;
                    end
                end
                PFC_RD_WAIT: begin
                    rd_state_reg <= PFC_RD_FETCH;
                end
                PFC_RD_FETCH: begin
                    rd_state_reg <= PFC_RD_IDLE;
                end
                default: begin
                    rd_state_reg <= PFC_RD_IDLE;
                end
            endcase
        end
    end

    // a hidden location reads back as zero rather than stalling the core
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_read_word  <= `PFC_ZERO_WORD;
            o_read_valid <= 1'b0;
        end else begin
            o_read_valid <= (rd_state_reg == PFC_RD_FETCH);
            if (rd_state_reg == PFC_RD_FETCH) begin
                o_read_word <= hidden_addr ? `PFC_ZERO_WORD : i_flash_rdata;
            end
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    sequence s_rd_launch;
        rd_launch;
    endsequence

    sequence s_rd_finish;
        ##1 (rd_state_reg == PFC_RD_WAIT) ##1 o_skip_instr ##1 (!ctrl_reg.read_trig && o_read_valid);
    endsequence

    a_rsvd_bits_zero: assert property (@(posedge i_ref_clk)
        (o_sfr_rdata & `PFC_UNUSED_MASK) == 8'h00)
        else $error("reserved control bits read nonzero");

    a_cal_route: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        o_flash_rd |-> (o_flash_cal == o_sfr_rdata[`PFC_BIT_CAL]))
        else $error("read space select mismatch");

    a_cal_hidden: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        (o_skip_instr && hidden_addr) |-> (!o_flash_rd ##1 (o_read_word == `PFC_ZERO_WORD)))
        else $error("hidden calibration location exposed");

    a_wr_allow_gate: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        o_wr_start |-> o_sfr_rdata[`PFC_BIT_ALLOW])
        else $error("write started without write allow");

    a_wr_launch: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        ($rose(ctrl_reg.write_trig) && wr_ok && wr_state_reg == PFC_WR_IDLE) |-> o_wr_start)
        else $error("write trigger did not start write");

    a_wr_no_abort: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        (wr_state_reg == PFC_WR_BUSY && !i_wr_done) |=> ctrl_reg.write_trig)
        else $error("write trigger cleared during write");

    a_wr_done_clear: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        (wr_state_reg == PFC_WR_BUSY && i_wr_done && !(i_sfr_wr && i_sfr_wdata[`PFC_BIT_WR]))
        |=> !ctrl_reg.write_trig)
        else $error("write trigger not cleared at completion");

    a_rd_sequence: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        s_rd_launch |-> s_rd_finish)
        else $error("read sequence timing wrong");

    a_rd_idle_quiet: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        !ctrl_reg.read_trig |-> !o_flash_rd)
        else $error("flash read without read trigger");

    a_cal_no_write: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        ctrl_reg.cal_select |-> !o_wr_start)
        else $error("write with calibration select set");

    a_rd_data_load: assert property (@(posedge i_ref_clk) disable iff (i_srst)
        o_flash_rd |=> (o_read_valid && o_read_word == $past(i_flash_rdata)))
        else $error("read word not presented");

    a_reset_clear: assert property (@(posedge i_ref_clk)
        i_srst |=> (o_sfr_rdata == `PFC_CTRL_RESET && !o_read_valid))
        else $error("control bits not cleared by reset");

endmodule : pfc_ctrl
`default_nettype wire

//--- hdl/pfc_map.svh
// constants for the program flash control register block
//
// Contract
// - bits 7 and 5..3 read as zero
// - calibration select steers reads to test area
// - calibration reads never expose config or id
// - writes happen only while write allow set
// - setting write trigger starts a flash write
// - software cannot clear the write trigger
// - hardware clears write trigger when write ends
// - read trigger starts read, hardware clears it
// - no flash read while read trigger clear
// - write with calibration select set is suppressed
// - fetch in second cycle, skip, present word
`ifndef PFC_MAP_SVH
`define PFC_MAP_SVH

// ****************************************
// register layout
// ****************************************
`define PFC_BIT_CAL       6
`define PFC_BIT_ALLOW     2
`define PFC_BIT_WR        1
`define PFC_BIT_RD        0
`define PFC_UNUSED_MASK   8'hb8
`define PFC_CTRL_RESET    8'h00
`define PFC_ZERO_WORD     14'h0000

// ****************************************
// calibration space locations that stay hidden
// ****************************************
`define PFC_CAL_CONFIG_ADDR 13'h0007
`define PFC_CAL_ID_ADDR     13'h0006

`endif

//--- hdl/pfc_pkg.sv
// types for the program flash control register block
package pfc_pkg;
    typedef enum logic [2:0] {
        PFC_RD_IDLE  = 3'b001,
        PFC_RD_WAIT  = 3'b010,
        PFC_RD_FETCH = 3'b100
    } pfc_rd_state_e;

    typedef enum logic [1:0] {
        PFC_WR_IDLE = 2'b01,
        PFC_WR_BUSY = 2'b10
    } pfc_wr_state_e;

    typedef struct packed {
        logic cal_select;
        logic write_allow;
        logic write_trig;
        logic read_trig;
    } pfc_ctrl_s;
endpackage : pfc_pkg

//--- tb/pfc_ctrl_test.sv
// self-checking bench for the program flash control register block
`timescale 1ns/1ps
`default_nettype none

module pfc_ctrl_test;
    logic        i_ref_clk = 1'b0;
    logic        i_srst = 1'b1;
    logic        i_sfr_wr = 1'b0;
    logic [7:0]  i_sfr_wdata = 8'h00;
    logic [7:0]  o_sfr_rdata;
    logic [12:0] i_flash_addr = 13'h0000;
    logic [13:0] i_flash_rdata = 14'h0000;
    logic        i_wr_done = 1'b0;
    logic        o_flash_rd;
    logic        o_flash_cal;
    logic        o_wr_start;
    logic        o_skip_instr;
    logic        o_read_valid;
    logic [13:0] o_read_word;
    int          fails = 0;
    int          num_checks = 0;
    int          cycles = 0;

    always #25 i_ref_clk = ~i_ref_clk;

    pfc_ctrl pfc_ctrl_inst (
        .i_ref_clk     (i_ref_clk),
        .i_srst        (i_srst),
        .i_sfr_wr      (i_sfr_wr),
        .i_sfr_wdata   (i_sfr_wdata),
        .o_sfr_rdata   (o_sfr_rdata),
        .i_flash_addr  (i_flash_addr),
        .i_flash_rdata (i_flash_rdata),
        .i_wr_done     (i_wr_done),
        .o_flash_rd    (o_flash_rd),
        .o_flash_cal   (o_flash_cal),
        .o_wr_start    (o_wr_start),
        .o_skip_instr  (o_skip_instr),
        .o_read_valid  (o_read_valid),
        .o_read_word   (o_read_word)
    );

    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input string name, input logic [13:0] got, input logic [13:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report

    // one-cycle register write, returns in the following cycle with strobe low
    task automatic sw(input logic [7:0] d);
        i_sfr_wr = 1'b1;
        i_sfr_wdata = d;
        @(negedge i_ref_clk);
        i_sfr_wr = 1'b0;
    endtask : sw

    // read with a clear attempt held in the cycle after the trigger
    task automatic do_read(input logic [7:0] d, input logic [12:0] a, input logic [13:0] w,
                           input logic exp_rd, input logic [13:0] exp_word);
        i_flash_addr = a;
        i_flash_rdata = w;
        i_sfr_wr = 1'b1;
        i_sfr_wdata = d;
        @(negedge i_ref_clk);
        i_sfr_wdata = d & 8'hfe;
        chk("read_trigger", {13'h0000, o_sfr_rdata[0]}, 14'h0001);
        chk("flash_rd_early", {13'h0000, o_flash_rd}, 14'h0000);
        @(negedge i_ref_clk);
        i_sfr_wr = 1'b0;
        chk("skip_instr", {13'h0000, o_skip_instr}, 14'h0001);
        chk("flash_rd", {13'h0000, o_flash_rd}, {13'h0000, exp_rd});
        chk("flash_cal", {13'h0000, o_flash_cal}, {13'h0000, d[6]});
        @(negedge i_ref_clk);
        chk("read_valid", {13'h0000, o_read_valid}, 14'h0001);
        chk("read_word", o_read_word, exp_word);
        chk("rd_cleared", {6'h00, o_sfr_rdata}, {6'h00, d & 8'h40});
    endtask : do_read

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset_and_layout;
        chk("reset_ctrl", {6'h00, o_sfr_rdata}, 14'h0000);
        chk("reset_word", o_read_word, 14'h0000);
        sw(8'hff);
        chk("unused_bits", {6'h00, o_sfr_rdata}, 14'h0047);
        chk("cal_out", {13'h0000, o_flash_cal}, 14'h0001);
        @(negedge i_ref_clk);
        sw(8'h00);
        chk("cleared", {6'h00, o_sfr_rdata}, 14'h0000);
        $display("test reset_and_layout done");
    endtask : t_reset_and_layout

    task automatic t_reads;
        do_read(8'h01, 13'h0123, 14'h2abc, 1'b1, 14'h2abc);
        do_read(8'h41, 13'h0010, 14'h1555, 1'b1, 14'h1555);
        do_read(8'h41, 13'h0007, 14'h3fff, 1'b0, 14'h0000);
        do_read(8'h41, 13'h0006, 14'h0abc, 1'b0, 14'h0000);
        sw(8'h00);
        $display("test reads done");
    endtask : t_reads

    task automatic t_write;
        sw(8'h06);
        chk("wr_start", {13'h0000, o_wr_start}, 14'h0001);
        chk("wr_set", {6'h00, o_sfr_rdata}, 14'h0006);
        @(negedge i_ref_clk);
        sw(8'h04);
        chk("wr_no_abort", {6'h00, o_sfr_rdata}, 14'h0006);
        chk("wr_one_pulse", {13'h0000, o_wr_start}, 14'h0000);
        i_wr_done = 1'b1;
        @(negedge i_ref_clk);
        i_wr_done = 1'b0;
        chk("wr_complete", {6'h00, o_sfr_rdata}, 14'h0004);
        $display("test write done");
    endtask : t_write

    // a write that must never reach the flash
    task automatic t_blocked(input logic [7:0] d);
        sw(d);
        chk("blocked_start", {13'h0000, o_wr_start}, 14'h0000);
        @(negedge i_ref_clk);
        chk("blocked_clear", {6'h00, o_sfr_rdata}, {6'h00, d & 8'h44});
        chk("blocked_start2", {13'h0000, o_wr_start}, 14'h0000);
        sw(8'h00);
        $display("test blocked write done");
    endtask : t_blocked

    // ****************************************
    // run control
    // ****************************************
    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 2000) begin
            fails++;
            final_report();
        end
    end

    initial begin
        repeat (10) @(negedge i_ref_clk);
        i_srst = 1'b0;
        t_reset_and_layout();
        t_reads();
        t_write();
        t_blocked(8'h02);
        t_blocked(8'h46);
        final_report();
    end
endmodule : pfc_ctrl_test

`default_nettype wire
